// ===== verilog/banked_memory_regs.vh
// Constants for the banked memory address decoder.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef BANKED_MEMORY_REGS_VH
`define BANKED_MEMORY_REGS_VH
// =============================================================
// Program space
`define PC_WIDTH 13
`define PROG_WORD_WIDTH 14
`define RESET_VECTOR 13'h0000
`define IRQ_VECTOR 13'h0004
`define PROG_WORDS_LARGE 8192
`define PROG_WORDS_SMALL 4096
// =============================================================
// Data space
`define DATA_ADDR_WIDTH 9
`define OFFSET_WIDTH 7
`define BANK_SEL_HI 6
`define BANK_SEL_LO 5
`define OFS_INDIRECT 7'h00
`define OFS_STATUS 7'h03
`define OFS_POINTER 7'h04
`define OFS_SFR_END 7'h1F
`define OFS_GPR_START 7'h20
`define OFS_COMMON_START 7'h70
`define OFS_BANK_END 7'h7F
`define STATUS_RESET 8'h18
`define POINTER_RESET 8'h00
`endif

// ===== verilog/program_store.v
// Program storage array with a fetch port and a separate data read port.
// Assumes one clock; a memory of DEPTH words with wrap of high bits.
`timescale 1ns/10ps
`include "banked_memory_regs.vh"
module program_store #(
  parameter DEPTH = `PROG_WORDS_LARGE,
  parameter AW = 13
) (
  input wire clk_sys_in,
  input wire [`PC_WIDTH-1:0] fetch_addr_in,
  output reg [`PROG_WORD_WIDTH-1:0] fetch_data_out,
  input wire [`PC_WIDTH-1:0] table_addr_in,
  output reg [`PROG_WORD_WIDTH-1:0] table_data_out,
  input wire load_in,
  input wire [`PC_WIDTH-1:0] load_addr_in,
  input wire [`PROG_WORD_WIDTH-1:0] load_data_in
);
  reg [`PROG_WORD_WIDTH-1:0] mem [0:DEPTH-1];

  // =============================================================
  // Ports
  // Upper address bits are dropped so an access past the array wraps.
  always @(posedge clk_sys_in) begin
    fetch_data_out <= mem[fetch_addr_in[AW-1:0]];
    table_data_out <= mem[table_addr_in[AW-1:0]];
    if (load_in) begin
      mem[load_addr_in[AW-1:0]] <= load_data_in;
    end
  end
endmodule // program_store

// ===== verilog/data_ram.v
// General purpose static RAM, one read and one write port.
// Assumes addresses already decoded to a dense index.
`timescale 1ns/10ps
module data_ram #(
  parameter DEPTH = 368,
  parameter AW = 9
) (
  input wire clk_sys_in,
  input wire we_in,
  input wire [AW-1:0] waddr_in,
  input wire [7:0] wdata_in,
  input wire [AW-1:0] raddr_in,
  output wire [7:0] rdata_out
);
  reg [7:0] mem [0:DEPTH-1];

  // =============================================================
  // Storage
  always @(posedge clk_sys_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
  end
  assign rdata_out = mem[raddr_in];
endmodule // data_ram

// ===== verilog/banked_memory_address_decoder.v
// Address decoder for program space and banked data registers.
// Assumes one core clock, synchronous reset and a one-cycle register port.
//
// The strobed register port was left to the implementer.
`timescale 1ns/10ps
`include "banked_memory_regs.vh"
module banked_memory_address_decoder #(
  parameter LARGE_VARIANT = 1
) (
  input wire clk_sys_in,
  input wire rst_in,
  // Program side.
  input wire pc_advance_in,
  input wire pc_load_in,
  input wire [`PC_WIDTH-1:0] pc_target_in,
  input wire irq_in,
  output reg [`PC_WIDTH-1:0] pc_out,
  output wire [`PROG_WORD_WIDTH-1:0] fetch_data_out,
  input wire [`PC_WIDTH-1:0] table_addr_in,
  output wire [`PROG_WORD_WIDTH-1:0] table_data_out,
  input wire prog_load_in,
  input wire [`PC_WIDTH-1:0] prog_load_addr_in,
  input wire [`PROG_WORD_WIDTH-1:0] prog_load_data_in,
  // Data side register port.
  input wire [`OFFSET_WIDTH-1:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rdata_out,
  output reg [1:0] bank_out,
  output reg [7:0] indirect_pointer_out
);
  localparam PROG_DEPTH = LARGE_VARIANT ? `PROG_WORDS_LARGE :
    `PROG_WORDS_SMALL;
  localparam PROG_AW = LARGE_VARIANT ? 13 : 12;
  localparam RAM_DEPTH = 368;

  reg [7:0] status_and_bank_select;
  reg [7:0] indirect_pointer;
  reg [`PC_WIDTH-1:0] next_pc;

  // =============================================================
  // Program counter
  always @* begin
    next_pc = pc_out;
    if (irq_in) begin
      next_pc = `IRQ_VECTOR;
    end else if (pc_load_in) begin
      next_pc = pc_target_in;
    end else if (pc_advance_in) begin
      next_pc = pc_out + 13'h0001;
    end
  end

  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      pc_out <= `RESET_VECTOR;
    end else begin
      pc_out <= next_pc;
    end
  end

  // The counter keeps all 13 bits; with LARGE_VARIANT = 0 the store drops the top bit.
  program_store #(.DEPTH(PROG_DEPTH), .AW(PROG_AW)) u_prog (
    .clk_sys_in(clk_sys_in),
    .fetch_addr_in(next_pc),
    .fetch_data_out(fetch_data_out),
    .table_addr_in(table_addr_in),
    .table_data_out(table_data_out),
    .load_in(prog_load_in),
    .load_addr_in(prog_load_addr_in),
    .load_data_in(prog_load_data_in)
  );

  // =============================================================
  // Data address decode
  // Returns {hit_ram, ram index} for a 9-bit file address.
  function [9:0] ram_index;
    input [8:0] fa;
    reg [6:0] ofs;
    begin
      ofs = fa[6:0];
      ram_index = 10'h000;
      if (ofs >= `OFS_COMMON_START) begin
        ram_index = {1'b1, 9'h000 + ofs - 9'h020};
      end else if (ofs >= `OFS_GPR_START) begin
        case (fa[8:7])
          2'b00: ram_index = {1'b1, 9'h000 + ofs - 9'h020};
          2'b01: ram_index = {1'b1, 9'h060 + ofs - 9'h020};
          2'b10: ram_index = {1'b1, 9'h0B0 + ofs - 9'h020};
          default: ram_index = {1'b1, 9'h100 + ofs - 9'h020};
        endcase
      end
    end
  endfunction

  wire [1:0] bank_sel = {status_and_bank_select[`BANK_SEL_HI],
    status_and_bank_select[`BANK_SEL_LO]};
  // Indirect access uses all 8 bits of the pointer plus the high bank bit.
  wire is_indirect = (addr_in == `OFS_INDIRECT);
  wire [8:0] file_addr = is_indirect ?
    {status_and_bank_select[`BANK_SEL_HI], indirect_pointer} :
    {bank_sel, addr_in};
  wire [6:0] ofs = file_addr[6:0];
  wire [9:0] ram_hit = ram_index(file_addr);
  // Status and pointer live at offsets 03h/04h of every bank.
  wire hit_status = (ofs == `OFS_STATUS);
  wire hit_pointer = (ofs == `OFS_POINTER);
  // Indirect through 00h itself reaches nothing.
  wire hit_self = (ofs == `OFS_INDIRECT);
  wire [7:0] ram_rdata;

  data_ram #(.DEPTH(RAM_DEPTH), .AW(9)) u_ram (
    .clk_sys_in(clk_sys_in),
    .we_in(wr_in & ram_hit[9]),
    .waddr_in(ram_hit[8:0]),
    .wdata_in(wdata_in),
    .raddr_in(ram_hit[8:0]),
    .rdata_out(ram_rdata)
  );

  // =============================================================
  // Special registers and read port
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      status_and_bank_select <= `STATUS_RESET;
      indirect_pointer <= `POINTER_RESET;
      rdata_out <= 8'h00;
      bank_out <= 2'h0;
      indirect_pointer_out <= 8'h00;
    end else begin
      if (wr_in && !hit_self) begin
        if (hit_status) begin
          status_and_bank_select <= wdata_in;
        end
        if (hit_pointer) begin
          indirect_pointer <= wdata_in;
        end
      end
      rdata_out <= 8'h00;
      if (rd_in && !hit_self) begin
        if (hit_status) begin
          rdata_out <= status_and_bank_select;
        end else if (hit_pointer) begin
          rdata_out <= indirect_pointer;
        end else if (ram_hit[9]) begin
          rdata_out <= ram_rdata;
        end
      end
      bank_out <= bank_sel;
      indirect_pointer_out <= indirect_pointer;
    end
  end
endmodule // banked_memory_address_decoder

// ===== verification/banked_memory_address_decoder_sva.sv
// Checker for the banked memory address decoder ports.
// Assumes one clock and a synchronous active high reset.
`timescale 1ns/10ps
module banked_memory_address_decoder_chk (
  input logic clk_sys_in,
  input logic rst_in,
  input logic pc_advance_in,
  input logic pc_load_in,
  input logic [12:0] pc_target_in,
  input logic irq_in,
  input logic [12:0] pc_out,
  input logic [6:0] addr_in,
  input logic [7:0] wdata_in,
  input logic wr_in,
  input logic rd_in,
  input logic [7:0] rdata_out,
  input logic [1:0] bank_out,
  input logic [7:0] indirect_pointer_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  chk_pc_reset_start: assert property ($fell(rst_in) |->
    pc_out == 13'h0000) else $error("pc not zero after reset");
  chk_irq_vector: assert property (irq_in |=> pc_out == 13'h0004)
    else $error("interrupt vector wrong");
  chk_pc_jump: assert property (pc_load_in && !irq_in |=>
    pc_out == $past(pc_target_in)) else $error("jump target lost");
  chk_pc_step_one: assert property (pc_advance_in && !pc_load_in &&
    !irq_in |=> pc_out == $past(pc_out) + 13'h0001)
    else $error("pc step wrong");
  chk_bank_select: assert property (wr_in && addr_in == 7'h03 |-> ##2
    bank_out == $past(wdata_in[6:5], 2)) else $error("bank not taken");
  chk_pointer_write: assert property (wr_in && addr_in == 7'h04 |-> ##2
    indirect_pointer_out == $past(wdata_in, 2)) else $error("pointer lost");
  chk_status_mirror: assert property (rd_in && addr_in == 7'h03 |=>
    rdata_out[6:5] == $past(bank_out)) else $error("status read wrong");
  chk_pointer_mirror: assert property (rd_in && addr_in == 7'h04 |=>
    rdata_out == $past(indirect_pointer_out)) else $error("pointer read");
  chk_unused_zero: assert property (rd_in && addr_in inside
    {7'h01, 7'h02, [7'h05:7'h1F]} |=> rdata_out == 8'h00)
    else $error("unimplemented read not zero");
endmodule // banked_memory_address_decoder_chk
bind banked_memory_address_decoder banked_memory_address_decoder_chk u_chk (
  .clk_sys_in, .rst_in, .pc_advance_in, .pc_load_in, .pc_target_in,
  .irq_in, .pc_out, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
  .bank_out, .indirect_pointer_out);

// ===== verification/banked_memory_address_decoder_tb.sv
// Self-checking bench for the banked memory address decoder.
// Assumes the small program variant so that program fetches wrap.
`timescale 1ns/10ps
module banked_memory_address_decoder_tb;
  logic clk_sys_in = 0, rst_in = 1, pc_advance_in = 0, pc_load_in = 0;
  logic irq_in = 0, prog_load_in = 0, wr_in = 0, rd_in = 0;
  logic [12:0] pc_target_in = 0, table_addr_in = 0, prog_load_addr_in = 0;
  logic [13:0] prog_load_data_in = 0, fetch_data_out, table_data_out;
  logic [12:0] pc_out;
  logic [6:0] addr_in = 0;
  logic [7:0] wdata_in = 0, rdata_out, indirect_pointer_out;
  logic [1:0] bank_out;
  int failures = 0, tests_run = 0;
  // Rows: write flag, offset, then write data or expected read data.
  localparam logic [15:0] rows [30] = '{16'h0318, 16'h0400, 16'hA0A5,
    16'hF03C, 16'h8338, 16'h703C, 16'hA05A, 16'h8420, 16'h8318, 16'h0420,
    16'h20A5, 16'h00A5, 16'h8077, 16'h2077, 16'h84A0, 16'h005A, 16'h8338,
    16'h005A, 16'h81FF, 16'h0100, 16'h8358, 16'hA011, 16'h8378, 16'hA022,
    16'h703C, 16'h2022, 16'h8358, 16'h2011, 16'h8318, 16'h2077};
  banked_memory_address_decoder #(.LARGE_VARIANT(0)) DUT (.*);
  initial forever #2 clk_sys_in = ~clk_sys_in;
  task chk(input logic [15:0] g, e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys_in) {wr_in, addr_in, wdata_in} <= {1'b1, a, d};
    @(posedge clk_sys_in) wr_in <= 0;
  endtask
  task rd(input logic [6:0] a, input logic [7:0] e);
    @(posedge clk_sys_in) {rd_in, addr_in} <= {1'b1, a};
    @(posedge clk_sys_in) rd_in <= 0;
    #1 chk(rdata_out, e);
  endtask
  task final_report;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_sys_in);
    rst_in <= 0;
    #1 chk(pc_out, 13'h0000);
    foreach (rows[i]) begin
      if (rows[i][15]) begin
        wr(rows[i][14:8], rows[i][7:0]);
        if (rows[i][14:8] == 7'h03) begin
          @(posedge clk_sys_in);
          #1 chk(bank_out, rows[i][6:5]);
        end
      end else
        rd(rows[i][14:8], rows[i][7:0]);
    end
    @(posedge clk_sys_in) begin
      {prog_load_in, prog_load_addr_in} <= {1'b1, 13'h0004};
      prog_load_data_in <= 14'h2ABC;
    end
    @(posedge clk_sys_in) begin
      {prog_load_addr_in, prog_load_data_in} <= {13'h0005, 14'h1234};
      {pc_advance_in, table_addr_in} <= {1'b1, 13'h1005};
    end
    @(posedge clk_sys_in) {prog_load_in, pc_advance_in} <= 2'b00;
    repeat (2) @(posedge clk_sys_in);
    #1 chk(table_data_out, 14'h1234);
    @(posedge clk_sys_in) irq_in <= 1;
    @(posedge clk_sys_in) irq_in <= 0;
    #1 chk(pc_out, 13'h0004);
    chk(fetch_data_out, 14'h2ABC);
    @(posedge clk_sys_in) {pc_load_in, pc_target_in} <= {1'b1, 13'h1FFF};
    @(posedge clk_sys_in) pc_load_in <= 0;
    #1 chk(pc_out, 13'h1FFF);
    final_report;
  end
  initial begin
    #20000 failures++;
    final_report;
  end
endmodule // banked_memory_address_decoder_tb
